/* src/ssfl_core.sv */
// segment selector, descriptor cache, segment choice, instruction offset and flags
// Function
// - table bit zero global, one local
// - requested level zero most privileged
// - effective level is lower of two
// - selector load caches base limit rights
// - cache kept until next selector load
// - default data, stack, code segments
// - fetch, stack, string store not overridable
// - base or stack pointer defaults stack
// - offset advances unless explicitly loaded
// - carry flag from top carry
// - parity flag on even low byte
// - auxiliary carry from bit three
// - zero and sign flags from result
// - overflow when carries into/out differ
// - single step traps then clears
// - maskable interrupt gated by enable
// - direction flag steps index registers
// - io allowed when level within field
// - flag pop changes enable if permitted
// - resume flag suppresses next debug fault
// - v86 flag real bases, privileged fault
// - query toggle writable only when enabled
// - alignment fault needs both enables
// - selector holds index, table, level
`timescale 1ns/100ps
`include "ssfl_params.svh"
module ssfl_core
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic i_maskable_int_pin,
  input wire logic i_debug_fault,
  input wire logic i_misaligned,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  output logic o_int_ack,
  output logic o_step_trap,
  output logic o_gp_fault,
  output logic o_align_fault,
  output logic o_debug_fault
);
  import ssfl_pkg::*;

  typedef struct packed
  {
    logic [31:0] flags_reg;
    logic [31:0] ip_reg;
    logic [5:0][15:0] sel_reg;
    logic [5:0][31:0] base_reg;
    logic [5:0][31:0] limit_reg;
    logic [5:0][7:0] rights_reg;
    logic [1:0] cpl_reg;
    logic pe_reg;
    logic am_reg;
    logic query_en_reg;
    logic [31:0] desc_base_reg;
    logic [31:0] desc_limit_reg;
    logic [7:0] desc_rights_reg;
    logic [2:0] seg_pick_reg;
    logic table_pick_reg;
    logic [1:0] eff_level_reg;
    logic v86_base_reg;
    logic step_armed_reg;
    logic resume_armed_reg;
    logic [31:0] rd_reg;
    logic ack_reg;
    logic int_ack_reg;
    logic step_trap_reg;
    logic gp_reg;
    logic align_reg;
    logic dbg_reg;
  } ssfl_state_s;

  ssfl_state_s s_reg;
  ssfl_state_s s_next;

  // parity of low byte: one when count of ones is even
  function automatic logic ssfl_even(input logic [7:0] v);
    ssfl_even = ~(^v);
  endfunction

  // level a is within (not above) level b
  function automatic logic ssfl_within(input logic [1:0] a, input logic [1:0] b);
    ssfl_within = (a <= b);
  endfunction

  logic req;
  logic wr;
  logic [31:0] wmask;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [1:0] io_priv_field;
  logic [2:0] sel_idx;
  logic [32:0] sum;
  logic [4:0] nib;
  logic [31:0] res;
  logic c_in_msb;
  logic [15:0] low_sum;
  logic sub;
  logic [31:0] fl;
  logic [31:0] pop_mask;
  logic [15:0] sel_new;
  logic [1:0] requested_priv_field;
  logic [2:0] ref_kind;
  logic [2:0] ovr_seg;
  logic ovr_en;
  logic base_sp;
  logic [2:0] pick;

  assign req = i_wb_cyc & i_wb_stb & ~s_reg.ack_reg;
  assign wr = req & i_wb_we;
  assign wmask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
  assign io_priv_field = s_reg.flags_reg[`SSFL_IO_PRIV_FIELD_LO+1:`SSFL_IO_PRIV_FIELD_LO];

  always_comb
  begin
    s_next = s_reg;
    s_next.ack_reg = req;
    s_next.int_ack_reg = 1'b0;
    s_next.step_trap_reg = 1'b0;
    s_next.gp_reg = 1'b0;
    s_next.align_reg = 1'b0;
    s_next.dbg_reg = 1'b0;
    wdat = i_wb_dat;
    fl = s_reg.flags_reg;
    sel_idx = i_wb_dat[18:16];
    sel_new = i_wb_dat[15:0];
    requested_priv_field = sel_new[1:0];
    sum = 33'h0;
    nib = 5'h0;
    res = 32'h0;
    c_in_msb = 1'b0;
    low_sum = 16'h0;
    sub = 1'b0;
    pop_mask = `SSFL_FLAGS_WMASK;
    ref_kind = i_wb_dat[2:0];
    ovr_en = i_wb_dat[3];
    ovr_seg = i_wb_dat[6:4];
    base_sp = i_wb_dat[7];
    pick = 3'(SSFL_SEG_DS);
    rdat = 32'h0;
    // interrupt gate
    if (i_maskable_int_pin && fl[`SSFL_IF])
    begin
      s_next.int_ack_reg = 1'b1;
    end
    // debug faults suppressed for one instruction when resume set
    if (i_debug_fault && !s_reg.resume_armed_reg)
    begin
      s_next.dbg_reg = 1'b1;
    end
    if (i_misaligned && fl[`SSFL_AC] && s_reg.am_reg)
    begin
      s_next.align_reg = 1'b1;
    end
    if (wr)
    begin
      case (i_wb_adr)
        8'(`SSFL_OFF_FLAGS):
        begin
          // flag pop: fixed bits kept, enable and toggle gated
          if (!ssfl_within(s_reg.cpl_reg, io_priv_field))
          begin
            pop_mask[`SSFL_IF] = 1'b0;
          end
          if (!s_reg.query_en_reg)
          begin
            pop_mask[`SSFL_ID] = 1'b0;
          end
          if (!(s_reg.cpl_reg == 2'h0))
          begin
            pop_mask[`SSFL_VM] = 1'b0;
          end
          pop_mask = pop_mask & wmask;
          fl = (fl & ~pop_mask) | (wdat & pop_mask) | `SSFL_FLAGS_FIXED1;
        end
        8'(`SSFL_OFF_IP):
        begin
          // explicit load from transfer, interrupt or exception
          s_next.ip_reg = wdat;
        end
        8'(`SSFL_OFF_SEL):
        begin
          if (sel_idx < 3'(`SSFL_NSEG))
          begin
            s_next.sel_reg[sel_idx] = sel_new;
            // hidden part refreshed only here
            s_next.base_reg[sel_idx] = (s_reg.pe_reg && !fl[`SSFL_VM]) ?
              s_reg.desc_base_reg : {12'h0, sel_new, 4'h0};
            s_next.limit_reg[sel_idx] = s_reg.desc_limit_reg;
            s_next.rights_reg[sel_idx] = s_reg.desc_rights_reg;
            s_next.table_pick_reg = sel_new[2];
            s_next.v86_base_reg = fl[`SSFL_VM];
            // effective level: lower numeric value wins
            s_next.eff_level_reg = (requested_priv_field < s_reg.cpl_reg) ?
              requested_priv_field : s_reg.cpl_reg;
          end
        end
        8'(`SSFL_OFF_CTRL):
        begin
          s_next.cpl_reg = wdat[1:0];
          s_next.pe_reg = wdat[4];
          s_next.am_reg = wdat[5];
          s_next.query_en_reg = wdat[6];
        end
        8'(`SSFL_OFF_DESC):
        begin
          s_next.desc_base_reg = wdat;
          s_next.desc_limit_reg = {12'h0, wdat[19:0]};
          s_next.desc_rights_reg = wdat[31:24];
        end
        8'(`SSFL_OFF_REF):
        begin
          case (ref_kind)
            3'(SSFL_REF_FETCH): pick = 3'(SSFL_SEG_CS);
            3'(SSFL_REF_STACK): pick = 3'(SSFL_SEG_SS);
            3'(SSFL_REF_STRDST): pick = 3'(SSFL_SEG_ES);
            default:
            begin
              pick = base_sp ? 3'(SSFL_SEG_SS) : 3'(SSFL_SEG_DS);
              if (ovr_en && ovr_seg < 3'(`SSFL_NSEG))
              begin
                pick = ovr_seg;
              end
            end
          endcase
          s_next.seg_pick_reg = pick;
        end
        8'(`SSFL_OFF_ALU):
        begin
          // operands a in [15:0], b in [31:16]; op bit: sel[3] means subtract
          sub = i_wb_sel[3];
          if (sub)
          begin
            sum = {17'h0, wdat[15:0]} - {17'h0, wdat[31:16]};
            nib = {1'b0, wdat[3:0]} - {1'b0, wdat[19:16]};
            // borrow into the sign bit from the low fifteen bits
            low_sum = {1'b0, wdat[14:0]} - {1'b0, wdat[30:16]};
            c_in_msb = low_sum[15];
          end
          else
          begin
            sum = {17'h0, wdat[15:0]} + {17'h0, wdat[31:16]};
            nib = {1'b0, wdat[3:0]} + {1'b0, wdat[19:16]};
            // carry into the sign bit from the low fifteen bits
            low_sum = {1'b0, wdat[14:0]} + {1'b0, wdat[30:16]};
            c_in_msb = low_sum[15];
          end
          res = {16'h0, sum[15:0]};
          fl[`SSFL_CF] = sum[16];
          fl[`SSFL_PF] = ssfl_even(res[7:0]);
          fl[`SSFL_AF] = nib[4];
          fl[`SSFL_ZF] = (res[15:0] == 16'h0);
          fl[`SSFL_SF] = res[15];
          fl[`SSFL_OF] = c_in_msb ^ sum[16];
        end
        8'(`SSFL_OFF_STEP):
        begin
          // one instruction retires: length in low byte, bit 9 privileged op, bit 10 io op
          s_next.ip_reg = s_reg.ip_reg + {24'h0, wdat[7:0]};
          s_next.resume_armed_reg = fl[`SSFL_RF];
          fl[`SSFL_RF] = 1'b0;
          if (wdat[9] && s_reg.pe_reg && fl[`SSFL_VM])
          begin
            s_next.gp_reg = 1'b1;
          end
          if (wdat[10] && s_reg.pe_reg && !ssfl_within(s_reg.cpl_reg, io_priv_field))
          begin
            s_next.gp_reg = 1'b1;
          end
          if (s_reg.step_armed_reg)
          begin
            s_next.step_trap_reg = 1'b1;
            fl[`SSFL_TF] = 1'b0;
          end
          s_next.step_armed_reg = fl[`SSFL_TF];
        end
        default:
        begin
        end
      endcase
    end
    s_next.flags_reg = fl;
    case (i_wb_adr)
      8'(`SSFL_OFF_FLAGS): rdat = s_reg.flags_reg;
      8'(`SSFL_OFF_IP): rdat = s_reg.ip_reg;
      8'(`SSFL_OFF_CTRL):
        rdat = {25'h0, s_reg.query_en_reg, s_reg.am_reg, s_reg.pe_reg, 2'h0, s_reg.cpl_reg};
      8'(`SSFL_OFF_REF): rdat = {29'h0, s_reg.seg_pick_reg};
      8'(`SSFL_OFF_EFF):
        rdat = {28'h0, s_reg.v86_base_reg, s_reg.table_pick_reg, s_reg.eff_level_reg};
      8'(`SSFL_OFF_STAT):
        // string step: +/-1 per direction flag
        rdat = s_reg.flags_reg[`SSFL_DF] ? 32'hffff_ffff : 32'h0000_0001;
      8'(`SSFL_OFF_SEL): rdat = {16'h0, s_reg.sel_reg[sel_idx < 3'(`SSFL_NSEG) ? sel_idx : 3'h0]};
      8'(`SSFL_OFF_DESC): rdat = s_reg.base_reg[s_reg.seg_pick_reg < 3'(`SSFL_NSEG) ?
        s_reg.seg_pick_reg : 3'h0];
      default: rdat = 32'h0;
    endcase
    s_next.rd_reg = req ? rdat : 32'h0;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      s_reg <= '0;
      s_reg.flags_reg <= `SSFL_FLAGS_RST;
      s_reg.ip_reg <= `SSFL_IP_RST;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign o_wb_dat = s_reg.rd_reg;
  assign o_wb_ack = s_reg.ack_reg;
  assign o_int_ack = s_reg.int_ack_reg;
  assign o_step_trap = s_reg.step_trap_reg;
  assign o_gp_fault = s_reg.gp_reg;
  assign o_align_fault = s_reg.align_reg;
  assign o_debug_fault = s_reg.dbg_reg;

  property p_int_gate;
    @(posedge i_clk) disable iff (i_rst)
    o_int_ack |-> $past(s_reg.flags_reg[`SSFL_IF]);
  endproperty
  a_int_gate: assert property (p_int_gate) else $error("int ack with enable clear");

  property p_fixed_bits;
    @(posedge i_clk) disable iff (i_rst)
    (s_reg.flags_reg & ~`SSFL_FLAGS_WMASK) == `SSFL_FLAGS_FIXED1;
  endproperty
  a_fixed_bits: assert property (p_fixed_bits) else $error("fixed flag bit moved");

  property p_id_lock;
    @(posedge i_clk) disable iff (i_rst)
    !s_reg.query_en_reg |=> $stable(s_reg.flags_reg[`SSFL_ID]);
  endproperty
  a_id_lock: assert property (p_id_lock) else $error("toggle bit moved");

  property p_if_pop;
    @(posedge i_clk) disable iff (i_rst)
    !ssfl_within(s_reg.cpl_reg, io_priv_field) |=> $stable(s_reg.flags_reg[`SSFL_IF]);
  endproperty
  a_if_pop: assert property (p_if_pop) else $error("enable changed above io level");

  property p_ack_pulse;
    @(posedge i_clk) disable iff (i_rst)
    o_wb_ack |=> !o_wb_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");

  property p_eff_level;
    @(posedge i_clk) disable iff (i_rst)
    ssfl_within(s_reg.eff_level_reg, 2'h3) && $changed(s_reg.eff_level_reg) |->
      s_reg.eff_level_reg <= $past(s_reg.cpl_reg);
  endproperty
  a_eff_level: assert property (p_eff_level) else $error("eff level above current");

  property p_step_clear;
    @(posedge i_clk) disable iff (i_rst)
    o_step_trap |-> !s_reg.flags_reg[`SSFL_TF];
  endproperty
  a_step_clear: assert property (p_step_clear) else $error("step flag left set");

  property p_align;
    @(posedge i_clk) disable iff (i_rst)
    o_align_fault |-> $past(s_reg.am_reg && s_reg.flags_reg[`SSFL_AC] && i_misaligned);
  endproperty
  a_align: assert property (p_align) else $error("align fault not enabled");
endmodule

/* include/ssfl_params.svh */
// offsets, flag bit positions, reset values and widths for the segment/flags block
`ifndef SSFL_PARAMS_SVH
`define SSFL_PARAMS_SVH
`define SSFL_OFF_FLAGS 32'h00
`define SSFL_OFF_IP 32'h04
`define SSFL_OFF_SEL 32'h08
`define SSFL_OFF_CTRL 32'h0c
`define SSFL_OFF_REF 32'h10
`define SSFL_OFF_ALU 32'h14
`define SSFL_OFF_STEP 32'h18
`define SSFL_OFF_STAT 32'h1c
`define SSFL_OFF_DESC 32'h20
`define SSFL_OFF_EFF 32'h24
`define SSFL_CF 0
`define SSFL_PF 2
`define SSFL_AF 4
`define SSFL_ZF 6
`define SSFL_SF 7
`define SSFL_TF 8
`define SSFL_IF 9
`define SSFL_DF 10
`define SSFL_OF 11
`define SSFL_IO_PRIV_FIELD_LO 12
`define SSFL_NT 14
`define SSFL_RF 16
`define SSFL_VM 17
`define SSFL_AC 18
`define SSFL_ID 21
`define SSFL_FLAGS_RST 32'h0000_0002
`define SSFL_FLAGS_FIXED1 32'h0000_0002
`define SSFL_FLAGS_WMASK 32'h0027_7fd5
`define SSFL_IP_RST 32'h0000_fff0
`define SSFL_SEL_RST 16'h0000
`define SSFL_NSEG 6
`endif

/* include/ssfl_pkg.sv */
// types for the segment select and flags block
package ssfl_pkg;
  typedef enum logic [2:0]
  {
    SSFL_SEG_ES = 3'h0,
    SSFL_SEG_CS = 3'h1,
    SSFL_SEG_SS = 3'h2,
    SSFL_SEG_DS = 3'h3,
    SSFL_SEG_FS = 3'h4,
    SSFL_SEG_GS = 3'h5
  } ssfl_seg_e;
  typedef enum logic [2:0]
  {
    SSFL_REF_FETCH = 3'h0,
    SSFL_REF_STACK = 3'h1,
    SSFL_REF_STRDST = 3'h2,
    SSFL_REF_DATA = 3'h3
  } ssfl_ref_e;
  typedef enum logic [1:0]
  {
    SSFL_ST_IDLE = 2'b00,
    SSFL_ST_ACK = 2'b01
  } ssfl_state_e;
endpackage

/* bench/segment_select_flags_logic_test.sv */
// self-checking bench for the segment select and flags block
`timescale 1ns/100ps
`include "ssfl_params.svh"
module segment_select_flags_logic_test;
  logic i_clk = 0;
  logic i_rst = 1;
  logic cyc = 0;
  logic stb = 0;
  logic we = 0;
  logic irq = 0;
  logic dbg = 0;
  logic mis = 0;
  logic [7:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] dat = 0;
  logic [31:0] rd;
  logic [31:0] o_dat;
  logic ack, iack, strap, gp, af, df;
  int mismatches = 0;
  int tests_run = 0;
  int flg, ip, current_priv_level, qen, a, b, n_int, n_st, n_gp, n_al, n_db;
  logic [7:0] rv[7] = '{8'h58, 8'h39, 8'h4a, 8'h83, 8'h03, 8'h5b, 8'hbb};
  int rs[7] = '{1, 2, 0, 2, 3, 5, 3};
  ssfl_core dut_u
  (
    .i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat), .i_maskable_int_pin(irq),
    .i_debug_fault(dbg), .i_misaligned(mis), .o_wb_dat(o_dat), .o_wb_ack(ack),
    .o_int_ack(iack), .o_step_trap(strap), .o_gp_fault(gp), .o_align_fault(af),
    .o_debug_fault(df)
  );
  initial
  begin
    forever #20 i_clk = ~i_clk;
  end
  // pulse counters on the event outputs
  always @(posedge i_clk)
  begin
    n_int += (iack === 1'b1);
    n_st += (strap === 1'b1);
    n_gp += (gp === 1'b1);
    n_al += (af === 1'b1);
    n_db += (df === 1'b1);
  end
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // classic single cycle, held until ack is sampled
  task wb(input logic w, input logic [7:0] ad, input logic [31:0] d, input logic [3:0] s);
    @(posedge i_clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= ad;
    dat <= d;
    sel <= s;
    @(posedge i_clk);
    // only the watchdog ends a wait that never sees ack
    while (ack !== 1'b1)
    begin
      @(posedge i_clk);
    end
    rd = o_dat;
    cyc <= 0;
    stb <= 0;
  endtask
  task rc(input string nm, input logic [7:0] ad, input logic [31:0] e);
    wb(0, ad, 0, 4'hf);
    chk(nm, rd, e);
  endtask
  task ctl(input int c, input int p, input int m, input int q);
    current_priv_level = c;
    qen = q;
    wb(1, `SSFL_OFF_CTRL, c | p << 4 | m << 5 | q << 6, 4'hf);
  endtask
  // flag pop with the model's gating of the protected bits
  task fw(input int d);
    int m;
    m = `SSFL_FLAGS_WMASK;
    if (current_priv_level > flg[13:12])
      m[9] = 0;
    if (current_priv_level != 0)
      m[17] = 0;
    if (qen == 0)
      m[21] = 0;
    flg = flg & ~m | d & m | 2;
    wb(1, `SSFL_OFF_FLAGS, d, 4'hf);
  endtask
  task st(input int len, input int pr, input int io);
    ip = ip + len;
    wb(1, `SSFL_OFF_STEP, len | pr << 9 | io << 10, 4'hf);
  endtask
  task alu(input int x, input int y, input int s);
    int r, c, h, v, p, z;
    x &= 'hffff;
    y &= 'hffff;
    s &= 1;
    r = s ? x - y : x + y;
    c = s ? x < y : r >> 16 & 1;
    h = s ? (x & 15) < (y & 15) : ((x & 15) + (y & 15)) >> 4;
    v = (s ? (x ^ y) & (x ^ r) : ~(x ^ y) & (x ^ r)) >> 15 & 1;
    r &= 'hffff;
    p = !(^r[7:0]);
    z = r == 0;
    flg = flg & ~'h8d5 | c | p << 2 | h << 4 | z << 6 | r[15] << 7 | v << 11;
    wb(1, `SSFL_OFF_ALU, y << 16 | x, s ? 4'hf : 4'h7);
    rc("alu flags", `SSFL_OFF_FLAGS, flg);
  endtask
  task pulse(input int len);
    irq <= 1;
    repeat (len) @(posedge i_clk);
    irq <= 0;
    repeat (3) @(posedge i_clk);
  endtask
  initial
  begin
    #(40 * 5000);
    mismatches++;
    wrap_up;
  end
  initial
  begin
    a = $urandom(32'h1868);
    repeat (16) @(posedge i_clk);
    i_rst <= 0;
    flg = `SSFL_FLAGS_RST;
    ip = `SSFL_IP_RST;
    rc("flags reset", `SSFL_OFF_FLAGS, flg);
    rc("ip reset", `SSFL_OFF_IP, ip);
    rc("unmapped", 8'h40, 0);
    ctl(0, 0, 0, 0);
    fw(-1);
    rc("flags all ones", `SSFL_OFF_FLAGS, flg);
    ctl(0, 0, 0, 1);
    fw(-1);
    rc("query bit", `SSFL_OFF_FLAGS, flg);
    fw(0);
    ctl(3, 0, 0, 0);
    fw(1 << 9);
    rc("enable gated", `SSFL_OFF_FLAGS, flg);
    n_int = 0;
    pulse(5);
    chk("masked int", n_int, 0);
    ctl(0, 0, 0, 0);
    fw(1 << 9);
    n_int = 0;
    pulse(5);
    chk("int acks", n_int, 5);
    alu('hffff, 1, 0);
    alu('h7fff, 1, 0);
    alu(0, 1, 1);
    alu('h8000, 1, 1);
    repeat (8) alu($urandom, $urandom, $urandom);
    fw(0);
    rc("string up", `SSFL_OFF_STAT, 1);
    fw(1 << 10);
    rc("string down", `SSFL_OFF_STAT, 32'hffffffff);
    ip = 'h1000;
    wb(1, `SSFL_OFF_IP, ip, 4'hf);
    st(5, 0, 0);
    st('hff, 0, 0);
    rc("ip advance", `SSFL_OFF_IP, ip);
    fw(1 << 8);
    n_st = 0;
    st(1, 0, 0);
    st(1, 0, 0);
    repeat (2) @(posedge i_clk);
    chk("step traps", n_st, 1);
    flg[8] = 0;
    rc("step clears", `SSFL_OFF_FLAGS, flg);
    fw(0);
    ctl(3, 1, 0, 0);
    n_gp = 0;
    st(1, 0, 1);
    repeat (2) @(posedge i_clk);
    chk("io fault", n_gp, 1);
    ctl(0, 1, 0, 0);
    st(1, 0, 1);
    st(1, 1, 0);
    repeat (2) @(posedge i_clk);
    chk("io allowed", n_gp, 1);
    fw(1 << 17);
    st(1, 1, 0);
    repeat (2) @(posedge i_clk);
    chk("v86 privileged", n_gp, 2);
    fw(1 << 18);
    n_al = 0;
    mis <= 1;
    @(posedge i_clk);
    mis <= 0;
    repeat (3) @(posedge i_clk);
    chk("align masked", n_al, 0);
    ctl(0, 1, 1, 0);
    mis <= 1;
    @(posedge i_clk);
    mis <= 0;
    repeat (3) @(posedge i_clk);
    chk("align fault", n_al, 1);
    fw(0);
    n_db = 0;
    dbg <= 1;
    @(posedge i_clk);
    dbg <= 0;
    repeat (3) @(posedge i_clk);
    chk("debug fault", n_db, 1);
    // resume flag armed by one retire hides the next debug fault
    fw(1 << 16);
    st(1, 0, 0);
    flg[16] = 0;
    dbg <= 1;
    @(posedge i_clk);
    dbg <= 0;
    repeat (3) @(posedge i_clk);
    chk("debug resumed", n_db, 1);
    rc("resume cleared", `SSFL_OFF_FLAGS, flg);
    for (int i = 0; i < 7; i++)
    begin
      wb(1, `SSFL_OFF_REF, rv[i], 4'hf);
      rc("segment choice", `SSFL_OFF_REF, rs[i]);
    end
    ctl(2, 1, 0, 0);
    a = $urandom;
    b = $urandom;
    wb(1, `SSFL_OFF_DESC, a, 4'hf);
    wb(1, `SSFL_OFF_SEL, 3 << 16 | ($urandom & 'h1fff) << 3 | 5, 4'hf);
    rc("local rpl one", `SSFL_OFF_EFF, 5);
    wb(1, `SSFL_OFF_REF, 3, 4'hf);
    rc("cached base", `SSFL_OFF_DESC, a);
    wb(1, `SSFL_OFF_DESC, b, 4'hf);
    rc("no reread", `SSFL_OFF_DESC, a);
    wb(1, `SSFL_OFF_SEL, 3 << 16 | ($urandom & 'h1fff) << 3 | 3, 4'hf);
    rc("global rpl three", `SSFL_OFF_EFF, 2);
    rc("reloaded base", `SSFL_OFF_DESC, b);
    wrap_up;
  end
endmodule
